// file: inc/acc_params.svh
// constants and rule summary for the converter control block
// What this block does
// - converter-on powers up and starts conversion
// - converts selected channel continuously once enabled
// - end of conversion loads result, sets flag
// - reading result high clears done flag
// - channel write aborts, clears flag, restarts
// - above high reference reads FFh and 03h
// - below low reference reads zero
// - result stored as ten bits split
// - four-bit channel select, sixteen inputs
// - clearing converter-on stops conversion
// - wait mode leaves converter running
// - halt disables; stabilization holds off results
// - control/status write clears done flag unless a conversion ends that cycle on the same channel
// - speed bit picks cpu/4 or cpu/2
// - high holds bits 9:2, low 1:0
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH
`define ACC_OFS_CSR        2'h0
`define ACC_OFS_RES_HIGH   2'h1
`define ACC_OFS_RES_LOW    2'h2
`define ACC_OFS_IRQ_STAT   2'h3
`define ACC_CSR_DONE_BIT   7
`define ACC_CSR_SPEED_BIT  6
`define ACC_CSR_ON_BIT     5
`define ACC_CSR_RSVD_BIT   4
`define ACC_CSR_RESET      8'h00
`define ACC_RES_RESET      10'h000
`define ACC_IRQ_DONE_BIT   0
`define ACC_IRQ_MASK_SHIFT 4
`define ACC_SAMPLE_CYCLES  4'h3
`define ACC_BIT_STEPS      4'hA
`define ACC_STAB_TIME_NS   20000
`define ACC_CLK_PERIOD_NS  100
`define ACC_STAB_CYCLES    ((`ACC_STAB_TIME_NS + `ACC_CLK_PERIOD_NS - 1) / `ACC_CLK_PERIOD_NS)
`endif

// file: inc/acc_pkg.sv
// types shared by the converter control block
package acc_pkg;
   typedef enum logic [1:0] {
      ACC_IDLE,
      ACC_STAB,
      ACC_SAMPLE,
      ACC_STEP
   } acc_state_e;
   typedef logic [9:0] acc_result_t;
endpackage

// file: design/acc_clk_div.sv
// converter clock tick generator, cpu/4 or cpu/2
`timescale 1ns/1ns
module acc_clk_div (
   input  wire logic i_core_clk,
   input  wire logic i_reset,
   input  wire logic i_run,
   input  wire logic i_fast,
   output logic      o_tick
);
   logic [1:0] cnt_r;
   always_ff @(posedge i_core_clk) begin
      if (i_reset || !i_run) begin
         cnt_r <= 2'h0;
      end else begin
         cnt_r <= cnt_r + 2'h1;
      end
   end
   // tick on last cycle of each converter period
   always_comb begin
      o_tick = i_fast ? cnt_r[0] : (cnt_r == 2'h3);
   end
endmodule

// file: design/acc_sar.sv
// successive approximation register with range clamping
`timescale 1ns/1ns
module acc_sar
   import acc_pkg::*;
#(
   parameter int WIDTH = 10
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_reset,
   input  wire logic             i_start,
   input  wire logic             i_step,
   input  wire logic             i_cmp_high,
   output logic [WIDTH-1:0]      o_value,
   output logic [3:0]            o_bit
);
   logic [WIDTH-1:0] trial_r;
   logic [3:0]       bit_r;
   always_ff @(posedge i_core_clk) begin
      if (i_reset || i_start) begin
         trial_r <= {1'b1, {(WIDTH-1){1'b0}}};
         bit_r   <= 4'(WIDTH - 1);
      end else if (i_step) begin
         // comparator says input above trial: keep bit
         if (!i_cmp_high) begin
            trial_r[bit_r] <= 1'b0;
         end
         if (bit_r != 4'h0) begin
            trial_r[bit_r - 4'h1] <= 1'b1;
            bit_r <= bit_r - 4'h1;
         end
      end
   end
   // saturates naturally: all kept gives 3FFh, none gives 000h
   always_comb begin
      o_value = trial_r;
      o_bit   = bit_r;
   end
endmodule

// file: design/acc_top.sv
// converter control: registers, sequencing, result and interrupt logic
//
// Local design decisions: the address map and the strobed register port.
`timescale 1ns/1ns
`include "acc_params.svh"
module acc_top
   import acc_pkg::*;
#(
   parameter int STAB_CYCLES = `ACC_STAB_CYCLES
) (
   input  wire logic        i_core_clk,
   input  wire logic        i_reset,
   input  wire logic [1:0]  i_addr,
   input  wire logic [7:0]  i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic        i_halt,
   input  wire logic        i_cmp_high,
   output logic [7:0]       o_rdata,
   output logic [3:0]       o_mux_sel,
   output logic             o_analog_on,
   output logic             o_sample,
   output logic [9:0]       o_dac_trial,
   output logic             o_irq
);
   import acc_pkg::*;

   logic             converter_on_r;
   logic             speed_r;
   logic [3:0]       channel_select_r;
   logic             done_r;
   acc_result_t      result_r;
   acc_state_e       state_r;
   logic [15:0]      stab_cnt_r;
   logic [3:0]       phase_cnt_r;
   logic             irq_stat_r;
   logic             irq_mask_r;
   logic             was_halted_r;
   logic             tick;
   logic             sar_start;
   logic             sar_step;
   logic [9:0]       sar_value;
   logic [3:0]       sar_bit;
   logic             csr_wr;
   logic             chan_change;
   logic             conv_abort;
   logic             active;
   logic             conv_end;
   logic             rd_high;

   function automatic logic hit(input logic [1:0] a, input logic [1:0] ofs);
      return a == ofs;
   endfunction

   always_comb begin
      csr_wr      = i_wr && hit(i_addr, `ACC_OFS_CSR);
      chan_change = csr_wr && (i_wdata[3:0] != channel_select_r);
      // a channel write while stabilizing must not cut the wait short
      conv_abort  = chan_change && (state_r == ACC_SAMPLE || state_r == ACC_STEP);
      rd_high     = i_rd && hit(i_addr, `ACC_OFS_RES_HIGH);
      // wait mode has no input here: converter unaffected
      active      = converter_on_r && !i_halt;
      sar_start   = (state_r == ACC_SAMPLE) && tick && (phase_cnt_r == 4'h0);
      sar_step    = (state_r == ACC_STEP) && tick;
      conv_end    = sar_step && (sar_bit == 4'h0);
   end

   acc_clk_div u_div (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_run      (active),
      .i_fast     (speed_r),
      .o_tick     (tick)
   );

   acc_sar #(
      .WIDTH (10)
   ) u_sar (
      .i_core_clk (i_core_clk),
      .i_reset    (i_reset),
      .i_start    (sar_start),
      .i_step     (sar_step),
      .i_cmp_high (i_cmp_high),
      .o_value    (sar_value),
      .o_bit      (sar_bit)
   );

   // control fields written by software
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         converter_on_r   <= 1'b0;
         speed_r          <= 1'b0;
         channel_select_r <= 4'h0;
      end else if (csr_wr) begin
         converter_on_r   <= i_wdata[`ACC_CSR_ON_BIT];
         speed_r          <= i_wdata[`ACC_CSR_SPEED_BIT];
         channel_select_r <= i_wdata[3:0];
      end
   end

   // remembers a halt so the next start waits out stabilization
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         was_halted_r <= 1'b0;
      end else if (i_halt) begin
         was_halted_r <= 1'b1;
      end else if (state_r == ACC_STAB && stab_cnt_r == 16'h0000) begin
         was_halted_r <= 1'b0;
      end
   end

   // conversion sequencer
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         state_r     <= ACC_IDLE;
         stab_cnt_r  <= 16'h0000;
         phase_cnt_r <= 4'h0;
      end else if (!active) begin
         state_r     <= ACC_IDLE;
         phase_cnt_r <= 4'h0;
      end else if (conv_abort) begin
         // abort and restart on the new channel
         state_r     <= ACC_SAMPLE;
         phase_cnt_r <= `ACC_SAMPLE_CYCLES;
      end else begin
         case (state_r)
            ACC_IDLE: begin
               // power up and begin
               if (was_halted_r) begin
                  state_r    <= ACC_STAB;
                  stab_cnt_r <= 16'(STAB_CYCLES - 1);
               end else begin
                  state_r     <= ACC_SAMPLE;
                  phase_cnt_r <= `ACC_SAMPLE_CYCLES;
               end
            end
            ACC_STAB: begin
               if (stab_cnt_r == 16'h0000) begin
                  state_r     <= ACC_SAMPLE;
                  phase_cnt_r <= `ACC_SAMPLE_CYCLES;
               end else begin
                  stab_cnt_r <= stab_cnt_r - 16'h0001;
               end
            end
            ACC_SAMPLE: begin
               if (tick) begin
                  if (phase_cnt_r == 4'h0) begin
                     state_r <= ACC_STEP;
                  end else begin
                     phase_cnt_r <= phase_cnt_r - 4'h1;
                  end
               end
            end
            ACC_STEP: begin
               if (conv_end) begin
                  // next conversion with no software action
                  state_r     <= ACC_SAMPLE;
                  phase_cnt_r <= `ACC_SAMPLE_CYCLES;
               end
            end
            default: begin
               state_r <= ACC_IDLE;
            end
         endcase
      end
   end

   // result not latched against software reads
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         result_r <= `ACC_RES_RESET;
      end else if (conv_end && !chan_change) begin
         result_r <= {sar_value[9:1], i_cmp_high};
      end
   end

   // done flag: set wins over clear
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         done_r <= 1'b0;
      end else if (conv_end && !chan_change && active) begin
         done_r <= 1'b1;
      end else if (rd_high || csr_wr) begin
         done_r <= 1'b0;
      end
   end

   // sticky interrupt status, write one to clear, set wins
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         irq_stat_r <= 1'b0;
         irq_mask_r <= 1'b0;
      end else begin
         if (conv_end && !chan_change && active) begin
            irq_stat_r <= 1'b1;
         end else if (i_wr && hit(i_addr, `ACC_OFS_IRQ_STAT) && i_wdata[`ACC_IRQ_DONE_BIT]) begin
            irq_stat_r <= 1'b0;
         end
         if (i_wr && hit(i_addr, `ACC_OFS_IRQ_STAT)) begin
            irq_mask_r <= i_wdata[`ACC_IRQ_MASK_SHIFT];
         end
      end
   end

   // read port, data one cycle after the strobe
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         case (i_addr)
            `ACC_OFS_CSR:      o_rdata <= {done_r, speed_r, converter_on_r, 1'b0, channel_select_r};
            `ACC_OFS_RES_HIGH: o_rdata <= result_r[9:2];
            `ACC_OFS_RES_LOW:  o_rdata <= {6'h00, result_r[1:0]};
            `ACC_OFS_IRQ_STAT: o_rdata <= {3'h0, irq_mask_r, 3'h0, irq_stat_r};
            default:           o_rdata <= 8'h00;
         endcase
      end else begin
         o_rdata <= 8'h00;
      end
   end

   // analog side outputs, all registered
   always_ff @(posedge i_core_clk) begin
      if (i_reset) begin
         o_mux_sel   <= 4'h0;
         o_analog_on <= 1'b0;
         o_sample    <= 1'b0;
         o_dac_trial <= 10'h000;
         o_irq       <= 1'b0;
      end else begin
         o_mux_sel   <= chan_change ? i_wdata[3:0] : channel_select_r;
         o_analog_on <= active;
         o_sample    <= active && !chan_change && (state_r == ACC_SAMPLE);
         o_dac_trial <= sar_value;
         o_irq       <= (irq_stat_r || (conv_end && !chan_change && active)) && irq_mask_r;
      end
   end
endmodule

// file: dv/acc_chk.sv
// port assertions for the converter control block
`timescale 1ns/1ns
module acc_chk (
   input wire logic       i_core_clk,
   input wire logic       i_reset,
   input wire logic [1:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic       i_wr,
   input wire logic       i_rd,
   input wire logic       i_halt,
   input wire logic [7:0] o_rdata,
   input wire logic [3:0] o_mux_sel,
   input wire logic       o_analog_on,
   input wire logic       o_sample,
   input wire logic       o_irq
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_reset);
   sequence s_csr_wr;
      i_wr && i_addr == 2'h0;
   endsequence
   sequence s_csr_rd;
      i_rd && i_addr == 2'h0;
   endsequence
   property p_mux_follow;
      s_csr_wr |=> o_mux_sel == $past(i_wdata[3:0]);
   endproperty
   a_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00) else $error("read data not idle");
   a_low_upper: assert property (i_rd && i_addr == 2'h2 |=> o_rdata[7:2] == 6'h00) else $error("low upper bits");
   a_halt_off: assert property (i_halt |=> !o_analog_on) else $error("powered in halt");
   a_mux_follow: assert property (p_mux_follow) else $error("mux not following channel");
   a_on_power: assert property (s_csr_wr ##0 i_wdata[5] ##1 !i_halt [*2] |-> o_analog_on)
      else $error("not powered");
   a_off_power: assert property (s_csr_wr ##0 !i_wdata[5] |-> ##2 !o_analog_on) else $error("still powered");
   a_high_clears: assert property (i_rd && i_addr == 2'h1 ##2 s_csr_rd |=> !o_rdata[7])
      else $error("flag kept after high read");
   a_wr_clears: assert property (s_csr_wr ##0 !o_analog_on ##2 s_csr_rd |=> !o_rdata[7])
      else $error("flag kept after write");
   a_irq_masked: assert property (i_wr && i_addr == 2'h3 && !i_wdata[4] |-> ##2 !o_irq)
      else $error("masked interrupt");
   a_sample_on: assert property ($rose(o_sample) |-> o_analog_on) else $error("sample unpowered");
   a_stab_hold: assert property ($fell(i_halt) |=> !o_sample [*4]) else $error("sampled before stable");
endmodule
bind acc_top acc_chk u_acc_chk (.i_core_clk, .i_reset, .i_addr, .i_wdata, .i_wr, .i_rd, .i_halt,
   .o_rdata, .o_mux_sel, .o_analog_on, .o_sample, .o_irq);

// file: dv/acc_ana_model.sv
// analog mux and comparator model facing the converter control
`timescale 1ns/1ns
module acc_ana_model (
   input  wire logic       i_core_clk,
   input  wire logic [3:0] i_mux_sel,
   input  wire logic       i_analog_on,
   input  wire logic [9:0] i_trial,
   output logic            o_cmp_high
);
   logic junk_r = 1'b0;
   // unpowered comparator output is meaningless, so it keeps changing
   always_ff @(posedge i_core_clk) begin
      junk_r <= ~junk_r;
   end
   always_comb begin
      if (!i_analog_on) o_cmp_high = junk_r;
      else if (i_mux_sel == 4'hF) o_cmp_high = 1'b1;
      else if (i_mux_sel == 4'h0) o_cmp_high = 1'b0;
      else o_cmp_high = {i_mux_sel, 6'h15} >= i_trial;
   end
endmodule

// file: dv/tb_acc_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ns
module tb_acc_top;
   logic       clk;
   logic       rst;
   logic [1:0] addr;
   logic [7:0] wdata;
   logic       wr;
   logic       rd;
   logic       halt;
   logic       cmp;
   logic [7:0] rdata;
   logic [3:0] mux;
   logic       aon;
   logic [9:0] trial;
   logic       irq;
   logic [7:0] d;
   logic [7:0] h;
   int         miscompares;
   int         compares;
   int         n;
   acc_top #(.STAB_CYCLES(4)) u_acc_top (.i_core_clk(clk), .i_reset(rst), .i_addr(addr), .i_wdata(wdata),
      .i_wr(wr), .i_rd(rd), .i_halt(halt), .i_cmp_high(cmp), .o_rdata(rdata), .o_mux_sel(mux),
      .o_analog_on(aon), .o_sample(), .o_dac_trial(trial), .o_irq(irq));
   acc_ana_model u_acc_ana_model (.i_core_clk(clk), .i_mux_sel(mux), .i_analog_on(aon), .i_trial(trial),
      .o_cmp_high(cmp));
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   task automatic wr_reg(input logic [1:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [1:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      v = rdata;
   endtask
   task automatic chk(input logic [9:0] got, input logic [9:0] exp);
      compares++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wait_done();
      n = 0;
      d = 8'h00;
      while (d[7] !== 1'b1 && n < 200) begin
         rd_reg(2'h0, d);
         n++;
      end
      chk(d[7], 1'b1);
   endtask
   // start a channel, then read low before high as software must
   task automatic conv(input logic [3:0] c, input logic f);
      wr_reg(2'h0, {1'b0, f, 2'b10, c});
      wait_done();
      rd_reg(2'h2, d);
      rd_reg(2'h1, h);
      chk({h, d[1:0]}, c == 4'h0 ? 10'h000 : c == 4'hF ? 10'h3FF : {c, 6'h15});
   endtask
   task automatic summarize();
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      rst = 1'b1;
      addr = 2'h0;
      wdata = 8'h00;
      wr = 1'b0;
      rd = 1'b0;
      halt = 1'b0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 4; a++) begin
         rd_reg(a[1:0], d);
         chk(d, 8'h00);
      end
      wr_reg(2'h3, 8'h10);
      for (int i = 0; i < 16; i += 5) conv(i[3:0], i[0]);
      rd_reg(2'h0, d);
      chk(d[7], 1'b0);
      wait_done();
      chk(irq, 1'b1);
      rd_reg(2'h1, h);
      chk(h, 8'hFF);
      rd_reg(2'h0, d);
      chk(d[7], 1'b0);
      conv(4'h5, 1'b0);
      chk(n > 20, 1'b1);
      conv(4'h6, 1'b1);
      chk(n < 20, 1'b1);
      wait_done();
      wr_reg(2'h0, 8'h66);
      rd_reg(2'h0, d);
      chk(d, 8'h66);
      wr_reg(2'h3, 8'h00);
      repeat (2) @(negedge clk);
      chk(irq, 1'b0);
      wr_reg(2'h3, 8'h10);
      wr_reg(2'h0, 8'h06);
      wr_reg(2'h3, 8'h11);
      repeat (3) @(negedge clk);
      chk(irq, 1'b0);
      rd_reg(2'h3, d);
      chk(d, 8'h10);
      repeat (100) @(posedge clk);
      rd_reg(2'h0, d);
      chk({aon, d}, 9'h006);
      wr_reg(2'h0, 8'h29);
      halt <= 1'b1;
      repeat (20) @(posedge clk);
      chk(aon, 1'b0);
      halt <= 1'b0;
      conv(4'h9, 1'b0);
      // flag left set, then a write while halted must still clear it
      wait_done();
      @(posedge clk);
      halt <= 1'b1;
      repeat (3) @(posedge clk);
      wr_reg(2'h0, 8'h29);
      rd_reg(2'h0, d);
      chk(d, 8'h29);
      summarize();
   end
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      summarize();
   end
endmodule
